// *** hw/dcs_top.sv ***
// Purpose: Drive four digital outputs, each from one selected status condition
// Assumes: All inputs synchronous to clk (10 MHz)
// Notes: Two register stages, outputs follow inputs two edges later
`timescale 1ns/1ps
`include "dcs_defines.svh"

// Functional notes
// - Keypad condition follows local keypad control
// - Brake condition follows braking transistor on
// - Foldback condition follows current foldback active
// - Fault condition follows fault; fault trips drive
// - Alarm condition follows alarm; never trips
// - Forward and reverse run command conditions
// - Forward and reverse actual motion conditions
// - Process error magnitude above tolerance
// - Network condition follows remote master command
// - Sequencer condition hands output to sequencer
// - Schedule condition hands output to scheduler
// - Zero speed when speed below threshold
// - At speed when reference-demand gap within tolerance
// - Set speed when speed above set point
// - Overload when current above overload point
// - Underload when current below underload point
// - Four outputs, two opto two relay, independent
module dcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Drive status and measurements
  input wire dcs_pkg::dcs_status_s status,
  input wire dcs_pkg::dcs_meas_s meas,
  input wire dcs_pkg::dcs_thresh_s thresh,
  // Per-output condition selects: 0..1 opto, 2..3 relay
  input wire logic [3:0][4:0] out_sel,
  // Output levels
  output logic [1:0] opto_out,
  output logic [1:0] relay_out,
  output logic drive_trip
);

  // Magnitude of a signed value, one bit wider so that the most
  // negative input does not wrap back to itself
  function automatic logic [16:0] mag17(input logic signed [16:0] v);
    logic [16:0] r;
    r = v[16] ? 17'(-v) : 17'(v);
    return r;
  endfunction : mag17

  // Pick one condition for an output; unknown codes give a low output
  function automatic logic pick(
    input logic [4:0] sel,
    input logic [18:0] cond,
    input logic net,
    input logic seq,
    input logic sched
  );
    logic r;
    r = 1'h0;
    if (sel == `DCS_SEL_NETWORK) begin
      r = net;
    end else if (sel == `DCS_SEL_SEQ) begin
      r = seq;
    end else if (sel == `DCS_SEL_SCHED) begin
      r = sched;
    end else if (sel < 5'(`DCS_NUM_COND)) begin
      r = cond[sel];
    end
    return r;
  endfunction : pick

  // Magnitudes and comparisons
  wire logic [16:0] speed_mag;
  wire logic [16:0] match_gap;
  wire logic [16:0] perr_mag;
  wire logic signed [16:0] speed_ext;
  wire logic signed [16:0] gap_raw;
  wire logic signed [16:0] perr_ext;

  assign speed_ext = 17'(meas.speed);
  assign perr_ext = 17'(meas.process_error);
  assign gap_raw = 17'(meas.speed_ref) - 17'(meas.speed_demand);
  assign speed_mag = mag17(speed_ext);
  assign match_gap = mag17(gap_raw);
  assign perr_mag = mag17(perr_ext);

  wire logic zero_spd;
  wire logic at_speed;
  wire logic set_speed;
  wire logic over_ld;
  wire logic under_ld;
  wire logic perr_hi;

  // Speed magnitude below threshold lets a brake interlock with motion
  assign zero_spd = speed_mag < {1'h0, thresh.zero_speed_threshold};
  assign at_speed = match_gap < {1'h0, thresh.speed_match_tolerance};
  // Signed speed, so reverse rotation never reads as above set point
  assign set_speed = meas.speed > $signed({1'h0, thresh.set_speed_point});
  assign over_ld = meas.current > thresh.overload_point;
  assign under_ld = meas.current < thresh.underload_point;
  assign perr_hi = perr_mag > {1'h0, thresh.process_err_tol};

  // Condition vector indexed by select code
  wire logic [18:0] cond_d;

  assign cond_d[0] = 1'h0;
  assign cond_d[1] = status.keypad_local;
  assign cond_d[2] = status.brake_on;
  assign cond_d[3] = status.foldback;
  assign cond_d[4] = status.fault;
  assign cond_d[5] = status.alarm;
  assign cond_d[6] = status.cmd_fwd;
  assign cond_d[7] = status.cmd_rev;
  assign cond_d[8] = status.motor_fwd;
  assign cond_d[9] = status.motor_rev;
  assign cond_d[10] = perr_hi;
  // Per-output sources are picked in the second stage
  assign cond_d[11] = 1'h0;
  assign cond_d[12] = 1'h0;
  assign cond_d[13] = 1'h0;
  assign cond_d[14] = zero_spd;
  assign cond_d[15] = at_speed;
  assign cond_d[16] = set_speed;
  assign cond_d[17] = over_ld;
  assign cond_d[18] = under_ld;

  // First stage: conditions, selects and per-output commands
  logic [18:0] cond_q;
  logic [3:0][4:0] sel_q;
  logic [3:0] net_q;
  logic [3:0] seq_q;
  logic [3:0] sched_q;
  logic fault_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= 19'h00000;
      sel_q <= {4{`DCS_SEL_RST}};
      net_q <= 4'h0;
      seq_q <= 4'h0;
      sched_q <= 4'h0;
      fault_q <= 1'h0;
    end else begin
      cond_q <= cond_d;
      sel_q <= out_sel;
      net_q <= status.net_cmd;
      seq_q <= status.seq_cmd;
      sched_q <= status.sched_cmd;
      fault_q <= status.fault;
    end
  end

  // Second stage: each output picks its own condition
  wire logic [3:0] out_d;

  genvar gi;
  generate
    for (gi = 0; gi < `DCS_NUM_OUT; gi++) begin : g_out
      assign out_d[gi] = pick(sel_q[gi], cond_q, net_q[gi], seq_q[gi], sched_q[gi]);
    end
  endgenerate

  logic [3:0] out_q;
  logic trip_q;

  // Outputs only from flops, so a switching select never glitches a relay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= `DCS_OUT_RST;
      trip_q <= 1'h0;
    end else begin
      out_q <= out_d;
      // Alarms are reported only; a fault also trips the drive
      trip_q <= fault_q;
    end
  end

  assign opto_out = out_q[1:0];
  assign relay_out = out_q[3:2];
  assign drive_trip = trip_q;

  // Helper: hold off checks until both stages carry real samples
  logic [1:0] warm_q;
  wire logic warm;

  assign warm = (warm_q == `DCS_WARM_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 2'h0;
    end else if (!warm) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  // Output 0 or 3 selects a code while a source holds, seen two edges later
  sequence s_sel0(logic [4:0] code, logic src);
    out_sel[0] == code && src;
  endsequence

  sequence s_sel3(logic [4:0] code, logic src);
    out_sel[3] == code && src;
  endsequence

  property p_follow0(logic [4:0] code, logic src);
    @(posedge clk) disable iff (!rst_n || !warm)
    s_sel0(code, src) |-> ##2 opto_out[0];
  endproperty

  property p_clear3(logic [4:0] code, logic src);
    @(posedge clk) disable iff (!rst_n || !warm)
    s_sel3(code, !src) |-> ##2 !relay_out[1];
  endproperty

  keypad_follow_a: assert property (p_follow0(`DCS_SEL_KEYPAD, status.keypad_local))
    else $error("keypad output not asserted");
  brake_clear_a: assert property (p_clear3(`DCS_SEL_BRAKE, status.brake_on))
    else $error("brake output set while transistor off");
  foldback_follow_a: assert property (p_follow0(`DCS_SEL_FOLDBACK, status.foldback))
    else $error("foldback output not asserted");
  fault_trip_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    status.fault |-> ##2 drive_trip)
    else $error("fault did not trip drive");
  alarm_notrip_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    (status.alarm && !status.fault) |-> ##2 !drive_trip)
    else $error("alarm tripped drive");
  cmd_rev_a: assert property (p_clear3(`DCS_SEL_CMD_REV, status.cmd_rev))
    else $error("reverse command output wrong");
  motor_fwd_a: assert property (p_follow0(`DCS_SEL_MOT_FWD, status.motor_fwd))
    else $error("motor forward output not asserted");
  proc_err_a: assert property (p_follow0(`DCS_SEL_PROC_ERR, perr_hi))
    else $error("process error output not asserted");
  network_bit_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    out_sel[2] == `DCS_SEL_NETWORK |-> ##2 relay_out[0] == $past(status.net_cmd[2], 2))
    else $error("network output does not follow command");
  zero_speed_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    (out_sel[1] == `DCS_SEL_ZERO_SPD && meas.speed == 16'sh0000
     && thresh.zero_speed_threshold != 16'h0000) |-> ##2 opto_out[1])
    else $error("zero speed output not asserted at rest");
  set_speed_a: assert property (p_clear3(`DCS_SEL_SET_SPEED, set_speed))
    else $error("set speed output set below set point");
  overload_a: assert property (p_follow0(`DCS_SEL_OVERLOAD, over_ld))
    else $error("overload output not asserted");

  // Outputs 1 and 2 get the same checks, so every output path is watched.
  // Antecedents below are built from raw inputs, not from the compare wires,
  // so a broken comparator cannot hide behind its own result.
  sequence s_sel1(logic [4:0] code, logic src);
    out_sel[1] == code && src;
  endsequence

  sequence s_sel2(logic [4:0] code, logic src);
    out_sel[2] == code && src;
  endsequence

  property p_follow1(logic [4:0] code, logic src);
    @(posedge clk) disable iff (!rst_n || !warm)
    s_sel1(code, src) |-> ##2 opto_out[1];
  endproperty

  property p_clear2(logic [4:0] code, logic src);
    @(posedge clk) disable iff (!rst_n || !warm)
    s_sel2(code, !src) |-> ##2 !relay_out[0];
  endproperty

  keypad_clear_a: assert property (p_clear3(`DCS_SEL_KEYPAD, status.keypad_local))
    else $error("keypad output set without local control");
  brake_follow_a: assert property (p_follow1(`DCS_SEL_BRAKE, status.brake_on))
    else $error("brake output not asserted");
  foldback_clear_a: assert property (p_clear2(`DCS_SEL_FOLDBACK, status.foldback))
    else $error("foldback output set without foldback");
  fault_clear_a: assert property (p_clear2(`DCS_SEL_FAULT, status.fault))
    else $error("fault output set without fault");
  alarm_follow_a: assert property (p_follow1(`DCS_SEL_ALARM, status.alarm))
    else $error("alarm output not asserted");
  cmd_fwd_a: assert property (p_follow1(`DCS_SEL_CMD_FWD, status.cmd_fwd))
    else $error("forward command output not asserted");
  motor_rev_a: assert property (p_clear2(`DCS_SEL_MOT_REV, status.motor_rev))
    else $error("motor reverse output set while not reversing");
  perr_clear_a: assert property (p_clear3(`DCS_SEL_PROC_ERR, meas.process_error != 16'sh0000))
    else $error("process error output set with no error");
  seq_bit_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    out_sel[1] == `DCS_SEL_SEQ |-> ##2 opto_out[1] == $past(status.seq_cmd[1], 2))
    else $error("sequencer output does not follow sequencer");
  sched_bit_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    out_sel[3] == `DCS_SEL_SCHED |-> ##2 relay_out[1] == $past(status.sched_cmd[3], 2))
    else $error("schedule output does not follow scheduler");
  // A zero threshold admits no speed magnitude, so the output must stay low
  zero_clear_a: assert property (p_clear3(`DCS_SEL_ZERO_SPD, thresh.zero_speed_threshold != 16'h0000))
    else $error("zero speed output set with zero threshold");
  at_speed_a: assert property (p_follow1(`DCS_SEL_AT_SPEED,
    meas.speed_ref == meas.speed_demand && thresh.speed_match_tolerance != 16'h0000))
    else $error("at speed output not asserted on matched speed");
  set_speed_on_a: assert property (p_follow1(`DCS_SEL_SET_SPEED,
    meas.speed > 16'sh0000 && thresh.set_speed_point == 16'h0000))
    else $error("set speed output not asserted above set point");
  overload_clear_a: assert property (p_clear2(`DCS_SEL_OVERLOAD, meas.current != 16'h0000))
    else $error("overload output set with no current");
  underload_a: assert property (p_clear2(`DCS_SEL_UNDERLOAD, thresh.underload_point != 16'h0000))
    else $error("underload output set with zero underload point");
  unused_code_a: assert property (@(posedge clk) disable iff (!rst_n || !warm)
    (out_sel[0] == `DCS_SEL_OFF || out_sel[0] > `DCS_SEL_UNDERLOAD) |-> ##2 !opto_out[0])
    else $error("off or unused code drove output high");

endmodule : dcs_top

// *** include/dcs_defines.svh ***
// Purpose: Constants for the drive output condition selector
// Assumes: Included by bare name
// Notes: Select codes index the per-cycle condition vector
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

`define DCS_SEL_W 5
`define DCS_NUM_COND 19
`define DCS_NUM_OUT 4

`define DCS_SEL_OFF 5'h00
`define DCS_SEL_KEYPAD 5'h01
`define DCS_SEL_BRAKE 5'h02
`define DCS_SEL_FOLDBACK 5'h03
`define DCS_SEL_FAULT 5'h04
`define DCS_SEL_ALARM 5'h05
`define DCS_SEL_CMD_FWD 5'h06
`define DCS_SEL_CMD_REV 5'h07
`define DCS_SEL_MOT_FWD 5'h08
`define DCS_SEL_MOT_REV 5'h09
`define DCS_SEL_PROC_ERR 5'h0A
`define DCS_SEL_NETWORK 5'h0B
`define DCS_SEL_SEQ 5'h0C
`define DCS_SEL_SCHED 5'h0D
`define DCS_SEL_ZERO_SPD 5'h0E
`define DCS_SEL_AT_SPEED 5'h0F
`define DCS_SEL_SET_SPEED 5'h10
`define DCS_SEL_OVERLOAD 5'h11
`define DCS_SEL_UNDERLOAD 5'h12

`define DCS_SEL_RST 5'h00
`define DCS_OUT_RST 4'h0
`define DCS_WARM_CYC 2'h2

`endif

// *** include/dcs_pkg.sv ***
// Purpose: Carrier types for the drive output condition selector
// Assumes: Speeds and errors are signed 16-bit, currents unsigned 16-bit
// Notes: Per-output command bits: bit 0..1 opto, bit 2..3 relay
package dcs_pkg;

  typedef struct packed {
    logic keypad_local;
    logic brake_on;
    logic foldback;
    logic fault;
    logic alarm;
    logic cmd_fwd;
    logic cmd_rev;
    logic motor_fwd;
    logic motor_rev;
    logic [3:0] net_cmd;
    logic [3:0] seq_cmd;
    logic [3:0] sched_cmd;
  } dcs_status_s;

  typedef struct packed {
    logic signed [15:0] speed;
    logic signed [15:0] speed_ref;
    logic signed [15:0] speed_demand;
    logic [15:0] current;
    logic signed [15:0] process_error;
  } dcs_meas_s;

  typedef struct packed {
    logic [15:0] zero_speed_threshold;
    logic [15:0] speed_match_tolerance;
    logic [15:0] set_speed_point;
    logic [15:0] overload_point;
    logic [15:0] underload_point;
    logic [15:0] process_err_tol;
  } dcs_thresh_s;

endpackage : dcs_pkg

// *** test/dcs_net_master.sv ***
// Purpose: Remote network master that commands the network-selected outputs
// Assumes: One command bit per output, same order as the selects
// Notes: Writes land on random cycles, so commands may stand for several cycles
`timescale 1ns/1ps
module dcs_net_master (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commanded levels
  output logic [3:0] net_cmd
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      net_cmd <= 4'h0;
    end else if ($urandom_range(2, 0) == 0) begin
      net_cmd <= 4'($urandom);
    end
  end
endmodule : dcs_net_master

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the output condition selector
// Assumes: Two-edge latency from inputs to outputs
// Notes: Small value ranges make threshold ties frequent
`timescale 1ns/1ps
`include "dcs_defines.svh"
module testbench;
  typedef struct {int cyc; logic [4:0] val;} dcs_note_s;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  dcs_pkg::dcs_status_s status;
  dcs_pkg::dcs_status_s st;
  dcs_pkg::dcs_meas_s meas;
  dcs_pkg::dcs_thresh_s thresh;
  logic [3:0][4:0] out_sel;
  logic [1:0] opto_out;
  logic [1:0] relay_out;
  logic drive_trip;
  logic [3:0] net_cmd;
  logic [4:0] e;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  dcs_note_s notes[$];
  dcs_note_s head;

  dcs_top dcs_top_inst (.clk(clk), .rst_n(rst_n), .status(status), .meas(meas), .thresh(thresh),
    .out_sel(out_sel), .opto_out(opto_out), .relay_out(relay_out), .drive_trip(drive_trip));
  dcs_net_master dcs_net_master_inst (.clk(clk), .rst_n(rst_n), .net_cmd(net_cmd));

  always #50 clk = ~clk;

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(logic [4:0] seen, logic [4:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic int mag(int v);
    return (v < 0) ? -v : v;
  endfunction : mag

  function automatic logic [15:0] sv(int lo, int hi);
    return 16'(int'($urandom_range(hi - lo, 0)) + lo);
  endfunction : sv

  function automatic logic cond_of(logic [4:0] sel, int i);
    case (sel)
      `DCS_SEL_KEYPAD: return status.keypad_local;
      `DCS_SEL_BRAKE: return status.brake_on;
      `DCS_SEL_FOLDBACK: return status.foldback;
      `DCS_SEL_FAULT: return status.fault;
      `DCS_SEL_ALARM: return status.alarm;
      `DCS_SEL_CMD_FWD: return status.cmd_fwd;
      `DCS_SEL_CMD_REV: return status.cmd_rev;
      `DCS_SEL_MOT_FWD: return status.motor_fwd;
      `DCS_SEL_MOT_REV: return status.motor_rev;
      `DCS_SEL_PROC_ERR: return mag(meas.process_error) > int'(thresh.process_err_tol);
      `DCS_SEL_NETWORK: return status.net_cmd[i];
      `DCS_SEL_SEQ: return status.seq_cmd[i];
      `DCS_SEL_SCHED: return status.sched_cmd[i];
      `DCS_SEL_ZERO_SPD: return mag(meas.speed) < int'(thresh.zero_speed_threshold);
      `DCS_SEL_AT_SPEED: begin
        return mag(int'(meas.speed_ref) - int'(meas.speed_demand)) < int'(thresh.speed_match_tolerance);
      end
      `DCS_SEL_SET_SPEED: return int'(meas.speed) > int'(thresh.set_speed_point);
      `DCS_SEL_OVERLOAD: return meas.current > thresh.overload_point;
      `DCS_SEL_UNDERLOAD: return meas.current < thresh.underload_point;
      default: return 1'h0;
    endcase
  endfunction : cond_of

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      n_errors++;
      close_out();
    end
  end

  // Results trail their inputs by two edges, so compare at the falling edge
  always @(negedge clk) begin
    if (notes.size() > 0 && notes[0].cyc + 2 == cyc) begin
      head = notes.pop_front();
      chk({drive_trip, relay_out, opto_out}, head.val);
    end
  end

  initial begin
    status = '0;
    meas = '0;
    thresh = '0;
    out_sel = '0;
    void'($urandom(73344));
    repeat (6) @(posedge clk);
    chk({drive_trip, relay_out, opto_out}, 5'h00);
    #1 rst_n = 1'h1;
    for (int n = 0; n < 2000; n++) begin
      if (n == 1000) begin
        rst_n = 1'h0;
        notes.delete();
        #10 chk({drive_trip, relay_out, opto_out}, 5'h00);
        @(posedge clk);
        #1 rst_n = 1'h1;
      end else begin
        @(posedge clk);
        #1;
      end
      // Build the word first so the design's status input changes only once
      st = 21'($urandom);
      st.net_cmd = net_cmd;
      status = st;
      meas = {sv(-7, 7), sv(-7, 7), sv(-7, 7), sv(0, 15), sv(-7, 7)};
      thresh = {sv(0, 8), sv(0, 8), sv(0, 8), sv(0, 15), sv(0, 15), sv(0, 8)};
      // Rotate selects so every code, reserved ones too, reaches every output
      for (int i = 0; i < 4; i++) begin
        out_sel[i] = 5'((n + 7 * i) % 32);
        e[i] = cond_of(out_sel[i], i);
      end
      e[4] = status.fault;
      notes.push_back('{cyc, e});
    end
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : testbench
